// File: rtl/rtd_pkg.sv
// Package of constants, register map and carrier types for the ring trip detector
package rtd_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] RTD_OFS_CONFIG  = 8'h00;
    localparam logic [7:0] RTD_OFS_BLANK   = 8'h04;
    localparam logic [7:0] RTD_OFS_STATUS  = 8'h08;
    localparam logic [7:0] RTD_OFS_IRQ     = 8'h0c;
    localparam logic [7:0] RTD_OFS_MASK    = 8'h10;
    localparam logic [7:0] RTD_OFS_AVERAGE = 8'h14;

    // ------------------------------------------------------------
    // Config field positions
    // ------------------------------------------------------------
    localparam int RTD_CFG_THR_LSB   = 0;   // trip_threshold, 7 bits, 0.5 mA steps
    localparam int RTD_CFG_ILIM_LSB  = 8;   // ringing_current_limit, 5 bits
    localparam int RTD_CFG_INTEG_BIT = 16;  // trip_integration_select
    localparam int RTD_CFG_TWO_BIT   = 17;  // 1 = two cycles, 0 = one cycle
    localparam int RTD_CFG_EN_BIT    = 18;  // ringing state active

    // Interrupt / status bit positions
    localparam int RTD_EV_HOOK  = 0;        // loop-closure flag
    localparam int RTD_EV_IND   = 1;        // per-cycle trip indication
    localparam int RTD_EV_LIMIT = 2;        // current-limit based indication
    localparam int RTD_NEV      = 3;

    // ------------------------------------------------------------
    // Reset values and fixed scaling
    // ------------------------------------------------------------
    localparam logic [31:0] RTD_CONFIG_RST = 32'h0002_0000;  // two cycles by default
    localparam logic [15:0] RTD_BLANK_RST  = 16'h0004;       // blanking, in ring cycles
    localparam logic [2:0]  RTD_MASK_RST   = 3'h0;
    localparam int RTD_ILIM_BASE_MA   = 50;   // code zero
    localparam int RTD_ILIM_STEP_MA   = 2;    // per count
    localparam int RTD_HALF_MA_PER_MA = 2;    // sample scale: LSB is 0.5 mA

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] current;   // loop current, 0.5 mA per LSB
        logic               wrap;      // generator phase wrap
        logic               valid;
    } rtd_sample_t;

    typedef enum logic [1:0] {
        RTD_IDLE  = 2'b00,
        RTD_BLANK = 2'b01,
        RTD_WATCH = 2'b10,
        RTD_TRIP  = 2'b11
    } rtd_state_t;

endpackage : rtd_pkg

// File: rtl/rtd_ring_trip.sv
// Ring trip detector: rectify, average per ring cycle, qualify and flag
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rtd_ring_trip
    import rtd_pkg::*;
#(
    parameter int ACC_W = 32
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Sample stream, same clock
    input  wire rtd_sample_t sample,
    // Host interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Configuration word as written by the host; only defined fields are kept
    logic [31:0]        ring_cfg, next_ring_cfg;
    logic [15:0]        blank_len, next_blank_len;
    logic [RTD_NEV-1:0] irq_stat, next_irq_stat;
    logic [RTD_NEV-1:0] irq_mask, next_irq_mask;

    // Per-cycle sums and the qualification state
    logic [ACC_W-1:0]   acc, next_acc;
    logic [ACC_W-1:0]   nsamp, next_nsamp;
    logic [ACC_W-1:0]   nlimit, next_nlimit;
    logic [ACC_W-1:0]   last_avg, next_last_avg;
    logic [15:0]        blank_cnt, next_blank_cnt;
    logic [1:0]         ind_cnt, next_ind_cnt;
    logic               hook, next_hook;
    rtd_state_t         state, next_state;

    // Decoded fields; the host sets them before ringing, so a change
    // in mid-cycle is not made to take effect cleanly
    logic [6:0]  thr;
    logic [4:0]  ilim_code;
    logic        half_wave;
    logic        two_cycles;
    logic        ring_on;
    assign thr        = ring_cfg[RTD_CFG_THR_LSB +: 7];
    assign ilim_code  = ring_cfg[RTD_CFG_ILIM_LSB +: 5];
    assign half_wave  = ring_cfg[RTD_CFG_INTEG_BIT];
    assign two_cycles = ring_cfg[RTD_CFG_TWO_BIT];
    assign ring_on    = ring_cfg[RTD_CFG_EN_BIT];

    // ------------------------------------------------------------
    // Datapath: rectify, limit decode, cycle result
    // ------------------------------------------------------------
    logic [15:0] rect;
    logic [15:0] ilim_half;
    logic [ACC_W-1:0] avg;
    logic        over_thr;
    logic        over_lim;
    logic        cycle_ind;
    logic        limit_ind;
    logic        cyc_end;

    always_comb begin
        // Half-wave drops the negative lobe; full-wave takes magnitude.
        // With AC-only ringing the two lobes cancel in a plain average, so
        // one lobe is kept; a DC bias survives full-wave and lifts the mean.
        if (sample.current[15])
            rect = half_wave ? 16'h0000 : 16'(-sample.current);
        else
            rect = 16'(sample.current);
    end

    // 50 mA + 2 mA/count, in 0.5 mA units, so it meets the rectified
    // sample directly; code 31 gives 224 units, well inside 16 bits
    assign ilim_half = 16'((RTD_ILIM_BASE_MA + RTD_ILIM_STEP_MA * int'(ilim_code))
                           * RTD_HALF_MA_PER_MA);
    assign over_lim  = (rect >= ilim_half);
    assign cyc_end   = sample.valid && sample.wrap;

    // Cycle average, including the closing sample.
    // The divide is combinational: it is used only at the wrap edge, but
    // it sets the longest path of the block and limits the clock rate.
    // Counts are as wide as the sum so a long cycle cannot wrap them.
    logic [ACC_W-1:0] tot_acc;
    logic [ACC_W-1:0] tot_n;
    logic [ACC_W-1:0] tot_lim;
    always_comb begin
        tot_acc = acc + ACC_W'(rect);
        tot_n   = nsamp + ACC_W'(1);
        tot_lim = nlimit + ACC_W'(over_lim);
        avg     = tot_acc / tot_n;
    end
    // Strict compare: an average equal to the threshold does not trip.
    // More than half: twice the limit count must exceed the total.
    assign over_thr  = (avg > ACC_W'(thr));
    assign limit_ind = ((tot_lim << 1) > tot_n);
    assign cycle_ind = over_thr || limit_ind;

    // ------------------------------------------------------------
    // Accumulators, next state
    // ------------------------------------------------------------
    // Sums run whenever ringing is on, blanking included, so the first
    // cycle watched after blanking is a whole one. Dropping ringing
    // clears them; the last average stays readable.
    always_comb begin
        next_acc      = acc;
        next_nsamp    = nsamp;
        next_nlimit   = nlimit;
        next_last_avg = last_avg;
        if (!ring_on) begin
            next_acc    = '0;
            next_nsamp  = '0;
            next_nlimit = '0;
        end else if (cyc_end) begin
            // Wrap sample closes the cycle; its value is already in avg
            next_acc      = '0;
            next_nsamp    = '0;
            next_nlimit   = '0;
            next_last_avg = avg;
        end else if (sample.valid) begin
            next_acc    = tot_acc;
            next_nsamp  = tot_n;
            next_nlimit = tot_lim;
        end
    end

    // ------------------------------------------------------------
    // Trip qualification state machine, next state
    // ------------------------------------------------------------
    logic trip_pulse;
    logic ind_pulse;
    logic lim_pulse;

    // Idle -> blank -> watch -> trip. A cycle without an indication
    // restarts the count, so only consecutive cycles confirm a trip.
    // Trip is held until ringing is removed, which also clears hook.
    always_comb begin
        next_state     = state;
        next_blank_cnt = blank_cnt;
        next_ind_cnt   = ind_cnt;
        next_hook      = hook;
        trip_pulse     = 1'b0;
        ind_pulse      = 1'b0;
        lim_pulse      = 1'b0;
        case (state)
            RTD_IDLE: begin
                // Blanking is reloaded from its length register on every entry
                next_ind_cnt = 2'h0;
                if (ring_on) begin
                    next_blank_cnt = blank_len;
                    next_state     = RTD_BLANK;
                end
            end
            RTD_BLANK: begin
                // Entry transients are ignored for whole cycles.
                // A count of zero goes straight to watch; a wrap in the
                // cycle of that change is neither counted nor judged.
                if (!ring_on)
                    next_state = RTD_IDLE;
                else if (blank_cnt == 16'h0000)
                    next_state = RTD_WATCH;
                else if (cyc_end)
                    next_blank_cnt = blank_cnt - 16'h0001;
            end
            RTD_WATCH: begin
                // Judged only at the wrap edge, once per ringing cycle
                if (!ring_on)
                    next_state = RTD_IDLE;
                else if (cyc_end) begin
                    ind_pulse = cycle_ind;
                    lim_pulse = limit_ind;
                    if (!cycle_ind)
                        next_ind_cnt = 2'h0;
                    else if (ind_cnt + 2'h1 >= (two_cycles ? 2'h2 : 2'h1)) begin
                        next_hook  = 1'b1;
                        trip_pulse = 1'b1;
                        next_state = RTD_TRIP;
                    end else
                        next_ind_cnt = ind_cnt + 2'h1;
                end
            end
            RTD_TRIP: begin
                // Hold off-hook until ringing is removed
                // Further wraps are not judged; the host reads hook and drops ringing
                if (!ring_on) begin
                    next_hook  = 1'b0;
                    next_state = RTD_IDLE;
                end
            end
            default: next_state = RTD_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // APB register file, next state
    // ------------------------------------------------------------
    // Writes take effect in the access phase; reads are captured at setup
    logic wr_en;
    logic rd_en;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;                                        // Zero wait states
    assign pslverr = 1'b0;

    // One pulse per event, in status bit order
    logic [RTD_NEV-1:0] events;
    assign events = {lim_pulse, ind_pulse, trip_pulse};

    // Bits of the config word that hold a field; the rest read back zero
    localparam logic [31:0] CFG_WMASK = 32'h0007_1f7f;
    logic [31:0] next_prdata;
    logic        next_irq;
    // Register writes, sticky events, interrupt level and read capture
    always_comb begin
        next_ring_cfg = ring_cfg;
        next_blank_len = blank_len;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_prdata   = prdata;
        // Unmapped and read-only offsets ignore writes
        if (wr_en) begin
            case (paddr)
                RTD_OFS_CONFIG: next_ring_cfg  = pwdata & CFG_WMASK;
                RTD_OFS_BLANK:  next_blank_len = pwdata[15:0];
                RTD_OFS_IRQ:    next_irq_stat  = irq_stat & ~pwdata[RTD_NEV-1:0];
                RTD_OFS_MASK:   next_irq_mask  = pwdata[RTD_NEV-1:0];
                default: ;
            endcase
        end
        // Set wins over a simultaneous clear
        next_irq_stat = next_irq_stat | events;
        // Interrupt level is registered from the status and mask it will see
        next_irq = |(next_irq_stat & next_irq_mask);
        // Read data stands from setup through the access phase
        if (rd_en) begin
            case (paddr)
                RTD_OFS_CONFIG:  next_prdata = ring_cfg;
                RTD_OFS_BLANK:   next_prdata = {16'h0000, blank_len};
                RTD_OFS_STATUS:  next_prdata = {27'h0, ind_cnt, state, hook};
                RTD_OFS_IRQ:     next_prdata = {29'h0, irq_stat};
                RTD_OFS_MASK:    next_prdata = {29'h0, irq_mask};
                RTD_OFS_AVERAGE: next_prdata = 32'(last_avg);
                default:         next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All state of the block; reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_cfg  <= RTD_CONFIG_RST;
            blank_len <= RTD_BLANK_RST;
            irq_stat  <= '0;
            irq_mask  <= RTD_MASK_RST;
            prdata    <= 32'h0000_0000;
            acc       <= '0;
            nsamp     <= '0;
            nlimit    <= '0;
            last_avg  <= '0;
            blank_cnt <= 16'h0000;
            ind_cnt   <= 2'h0;
            hook      <= 1'b0;
            state     <= RTD_IDLE;
            irq       <= 1'b0;
        end else begin
            ring_cfg  <= next_ring_cfg;
            blank_len <= next_blank_len;
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            prdata    <= next_prdata;
            acc       <= next_acc;
            nsamp     <= next_nsamp;
            nlimit    <= next_nlimit;
            last_avg  <= next_last_avg;
            blank_cnt <= next_blank_cnt;
            ind_cnt   <= next_ind_cnt;
            hook      <= next_hook;
            state     <= next_state;
            irq       <= next_irq;
        end
    end

endmodule : rtd_ring_trip

// File: bench/rtd_ring_trip_chk.sv
// Port checker for the ring trip detector, bound to the design top
`timescale 1ns/1ps
module rtd_ring_trip_chk
    import rtd_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Samples and interrupt
    input wire rtd_sample_t sample,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        wr_acc;
    logic        rd_acc;
    logic        cause;
    logic [31:0] cfg_shadow;
    logic [15:0] blank_shadow;
    logic [2:0]  mask_shadow;
    // Access phases and the events that may raise the interrupt
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign cause  = (wr_acc && paddr == RTD_OFS_MASK) || (sample.valid && sample.wrap);
    // Shadow copies of the config, blanking and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_shadow   <= RTD_CONFIG_RST;
            blank_shadow <= RTD_BLANK_RST;
            mask_shadow  <= RTD_MASK_RST;
        end else if (wr_acc) begin
            if (paddr == RTD_OFS_CONFIG) cfg_shadow <= pwdata & 32'h0007_1f7f;
            if (paddr == RTD_OFS_BLANK) blank_shadow <= pwdata[15:0];
            if (paddr == RTD_OFS_MASK) mask_shadow <= pwdata[2:0];
        end
    end
    a_zero_wait: assert property (pready && !pslverr) else $error("slave stalled or flagged error");
    a_config_readback: assert property (rd_acc && paddr == RTD_OFS_CONFIG |-> prdata == cfg_shadow)
        else $error("config readback wrong");
    a_blank_readback: assert property (rd_acc && paddr == RTD_OFS_BLANK |-> prdata == {16'h0, blank_shadow})
        else $error("blanking readback wrong");
    a_mask_readback: assert property (rd_acc && paddr == RTD_OFS_MASK |-> prdata == {29'h0, mask_shadow})
        else $error("mask readback wrong");
    a_unmapped_zero: assert property (rd_acc && paddr >= 8'h18 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_prdata_holds: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved outside a read setup");
    a_irq_masked: assert property (irq |-> (mask_shadow | $past(mask_shadow) | $past(mask_shadow, 2)) != 3'h0)
        else $error("interrupt high with mask clear");
    a_idle_no_hook: assert property (rd_acc && paddr == RTD_OFS_STATUS && !cfg_shadow[RTD_CFG_EN_BIT]
        && !$past(cfg_shadow[RTD_CFG_EN_BIT], 2) |-> prdata[2:0] == 3'h0)
        else $error("hook or state set while ringing off");
    a_irq_cause: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2) || $past(cause, 3)
        || $past(cause, 4)) else $error("interrupt rose away from a wrap or mask write");
    c_hook_read: cover property (rd_acc && paddr == RTD_OFS_STATUS && prdata[0]);
    c_irq_rise: cover property ($rose(irq));
    c_irq_clear: cover property (wr_acc && paddr == RTD_OFS_IRQ);
    c_limit_event: cover property (rd_acc && paddr == RTD_OFS_IRQ && prdata[RTD_EV_LIMIT]);
endmodule : rtd_ring_trip_chk

bind rtd_ring_trip rtd_ring_trip_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample(sample), .irq(irq));

// File: bench/rtd_host_model.sv
// Host processor model: APB master issuing register transfers
`timescale 1ns/1ps
module rtd_host_model (
    // Clock
    input  wire logic        pclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    int hangs = 0;
    // Bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end
    // One transfer, entered just after a rising edge; an idle cycle follows
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 64) begin
            n++;
            @(posedge pclk);
        end
        if (n == 64) hangs++;
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
endmodule : rtd_host_model

// File: bench/rtd_ring_trip_bench.sv
// Self-checking bench for the ring trip detector
`timescale 1ns/1ps
module rtd_ring_trip_bench
    import rtd_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    rtd_sample_t smp = '0;
    int bad_count = 0, check_count = 0;
    // Clock, design and host
    always #2 pclk = ~pclk;
    rtd_ring_trip dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample(smp), .irq(irq));
    rtd_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready));
    // Expected rectified average of one cycle
    function automatic int rect(int v, bit h); return (v < 0) ? (h ? 0 : -v) : v; endfunction : rect
    function automatic int avg(int n, int k, int hi, int lo, bit h);
        return (k * rect(hi, h) + (n - k) * rect(lo, h)) / n;
    endfunction : avg
    function automatic int lim(int c); return (RTD_ILIM_BASE_MA + RTD_ILIM_STEP_MA * c) * RTD_HALF_MA_PER_MA;
    endfunction : lim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
        if (host.hangs != 0) test_done();
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        if (host.hangs != 0) test_done();
        chk(q & m, e);
    endtask : rd_chk
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge pclk);
    endtask : irq_chk
    // Program while idle, then start ringing
    task automatic arm(input logic [31:0] cfg, input logic [15:0] blank);
        wr(RTD_OFS_CONFIG, 32'h0);
        wr(RTD_OFS_IRQ, 32'h7);
        wr(RTD_OFS_BLANK, {16'h0, blank});
        wr(RTD_OFS_CONFIG, cfg | (32'h1 << RTD_CFG_EN_BIT));
    endtask : arm
    // One ring cycle of n samples, the first k at hi, wrap on the last
    task automatic cyc(input int n, input int k, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            smp <= '{current: 16'((i < k) ? hi : lo), wrap: (i == n - 1), valid: 1'b1};
            @(posedge pclk);
        end
        smp <= '0;
        repeat (3) @(posedge pclk);
    endtask : cyc
    task automatic test_done();
        bad_count += host.hangs;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    // Watchdog on the whole run
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
    // Main sequence
    initial begin
        int a, b, c, rc, thr, j;
        logic h;
        void'($urandom(3684));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(8'h18, 32'hffff_ffff);
        wr(RTD_OFS_AVERAGE, 32'h0000_00ff);
        rd_chk(RTD_OFS_CONFIG, RTD_CONFIG_RST);
        rd_chk(RTD_OFS_BLANK, {16'h0, RTD_BLANK_RST});
        rd_chk(RTD_OFS_STATUS, 32'h0);
        rd_chk(RTD_OFS_IRQ, 32'h0);
        rd_chk(RTD_OFS_MASK, 32'h0);
        rd_chk(RTD_OFS_AVERAGE, 32'h0);
        rd_chk(8'h18, 32'h0);
        $display("test reset_values done");
        a = 2 * $urandom_range(10, 49);
        for (int i = 0; i < 4; i++) begin
            h = (i == 0);
            thr = (i < 2) ? (3 * a / 4) : ((i == 2) ? a : a - 1);
            arm(32'(thr) | (32'(h) << RTD_CFG_INTEG_BIT), 16'h0);
            cyc(8, 4, a, -a);
            rd_chk(RTD_OFS_AVERAGE, 32'(avg(8, 4, a, -a, h)));
            rd_chk(RTD_OFS_STATUS, 32'(avg(8, 4, a, -a, h) > thr), 32'h1);
        end
        $display("test rectify_threshold done");
        for (int t = 1; t >= 0; t--) begin
            b = $urandom_range(1, 3);
            arm(32'd10 | (32'(t) << RTD_CFG_TWO_BIT), 16'(b));
            repeat (b + t) cyc(8, 8, 60, 60);
            rd_chk(RTD_OFS_STATUS, (32'(t) << 3) | (32'(RTD_WATCH) << 1), 32'h1f);
            cyc(8, 8, 60, 60);
            rd_chk(RTD_OFS_STATUS, (32'(RTD_TRIP) << 1) | 32'h1, 32'h7);
            rd_chk(RTD_OFS_IRQ, 32'h3);
            irq_chk(1'b0);
            wr(RTD_OFS_MASK, 32'h1);
            irq_chk(1'b1);
            wr(RTD_OFS_IRQ, 32'h1);
            irq_chk(1'b0);
            rd_chk(RTD_OFS_STATUS, 32'h1, 32'h1);
            wr(RTD_OFS_MASK, 32'h0);
        end
        $display("test blank_count done");
        rc = $urandom_range(1, 30);
        for (int i = 0; i < 9; i++) begin
            c = (i < 3) ? 0 : ((i < 6) ? 31 : rc);
            j = i % 3;
            arm(32'd127 | (32'(c) << RTD_CFG_ILIM_LSB), 16'h0);
            cyc(16, (j == 1) ? 8 : 9, lim(c) - ((j == 2) ? 1 : 0), 0);
            rd_chk(RTD_OFS_IRQ, 32'(j == 0) << RTD_EV_LIMIT, 32'h4);
            rd_chk(RTD_OFS_STATUS, 32'(j == 0), 32'h1);
        end
        wr(RTD_OFS_CONFIG, 32'h0);
        rd_chk(RTD_OFS_STATUS, 32'h0, 32'h1);
        $display("test current_limit done");
        test_done();
    end
endmodule : rtd_ring_trip_bench
